// File: fault_pkg.sv
// Package of constants and types shared by the fault reaction ends
// Functional notes
// - Host holds bridge enable low 2.5 us
// - Self-test result 11 forces shutdown until reset
// - Watchdog failure forces shutdown until watchdog reset
// - Auto-retry fault sets flag, error 11, pin
// - Auto-retry tristates all bridges, stays normal mode
// - Auto-retry recovery: gone, read, ack 0 then 1
// - Reduced fault sets flag, error 11, pin
// - Reduced fault disables only failing half bridge
// - Reduced recovery: removed, read, ack toggled
// - Host enters configuration mode before writing ack
// - Warning sets flag, error 00, pin high
// - Warning takes no corrective action
// - Half bridge disable sources combined combinationally
// - Echo each half bridge enable state
// - Charge pump disable sources combined combinationally
// - Echo each charge pump enable state
// - Shutdown fault: flag, error 11, safe state
// - Shutdown exit: removed, read, enable pulse
// - Priority: shutdown, auto-retry, reduced, warning
package fault_pkg;
  localparam int unsigned NUM_HB = 3;
  localparam int unsigned NUM_CP = 2;
  localparam int unsigned CLK_FREQ_HZ = 20000000;
  // Bridge enable clear time in nanoseconds (2.5 us)
  localparam int unsigned CLEAR_TIME_NS = 2500;
  localparam int unsigned CLEAR_CYCLES = (CLEAR_TIME_NS * (CLK_FREQ_HZ / 1000000) + 999) / 1000;
  localparam int unsigned CNT_W = 8;
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_STD = 2'h3;
  localparam logic [1:0] SELFTEST_FAIL = 2'h3;
  localparam logic [1:0] FRC_FULL_OFF = 2'h0;
  localparam logic [1:0] FRC_REDUCED = 2'h1;
  // Host APB register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_HB_DIS = 8'h04;
  localparam logic [7:0] OFS_ACK = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  // Field positions
  localparam int unsigned CTRL_BRIDGE_EN_BIT = 0;
  localparam int unsigned CTRL_PUMP1_DIS_BIT = 1;
  localparam int unsigned CTRL_PUMP2_DIS_BIT = 2;
  localparam int unsigned CTRL_GLOBAL_DIS_BIT = 3;
  localparam int unsigned CMD_SW_RESET_BIT = 0;
  localparam int unsigned CMD_WDT_RESET_BIT = 1;
  localparam int unsigned CMD_CFG_MODE_BIT = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0;
  localparam logic [2:0] ACK_RESET = 3'h7;
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_SAFE_OFF,
    MODE_LOCKED
  } mode_e;
endpackage : fault_pkg

// File: fault_if.sv
// Interface joining the gate driver fault logic and its host controller
interface fault_if;
  import fault_pkg::*;
  logic bridge_enable_pin;
  logic global_disable_pin_n;
  logic fault_signal_pin;
  logic [2:0] half_bridge_disable_bit;
  logic pump_one_disable_bit;
  logic pump_two_disable_bit;
  logic [2:0] half_bridge_recovery_ack;
  logic config_mode;
  logic software_reset_command;
  logic watchdog_reset_command;
  logic flag_read;
  logic [1:0] frame_error_status_bits;
  logic [2:0] half_bridge_enable_echo;
  logic [1:0] pump_enable_echo;
  logic [7:0] fault_flags;
  modport device (
    input bridge_enable_pin, global_disable_pin_n, half_bridge_disable_bit, pump_one_disable_bit,
    input pump_two_disable_bit, half_bridge_recovery_ack, config_mode, software_reset_command,
    input watchdog_reset_command, flag_read,
    output fault_signal_pin, frame_error_status_bits, half_bridge_enable_echo, pump_enable_echo, fault_flags
  );
  modport host (
    output bridge_enable_pin, global_disable_pin_n, half_bridge_disable_bit, pump_one_disable_bit,
    output pump_two_disable_bit, half_bridge_recovery_ack, config_mode, software_reset_command,
    output watchdog_reset_command, flag_read,
    input fault_signal_pin, frame_error_status_bits, half_bridge_enable_echo, pump_enable_echo, fault_flags
  );
endinterface : fault_if

// File: fault_device.sv
// Fault reaction and half bridge / pump disable logic of the gate driver
module fault_device import fault_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  fault_if.device link,
  input wire logic shutdown_fault_i,
  input wire logic [2:0] autoretry_fault_i,
  input wire logic [2:0] reduced_fault_i,
  input wire logic warning_fault_i,
  input wire logic predriver_supply_uv_i,
  input wire logic [1:0] selftest_result_i,
  input wire logic watchdog_timeout_failure_i,
  input wire logic watchdog_reply_failure_i,
  output logic [2:0] hb_enable_o,
  output logic [1:0] pump_enable_o,
  output logic [1:0] mode_o
);
  // Pin synchronisers
  logic [1:0] en_sync, global_disable_pin_sync;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_sync <= 2'h0;
      global_disable_pin_sync <= 2'h0;
    end else begin
      en_sync <= {en_sync[0], link.bridge_enable_pin};
      global_disable_pin_sync <= {global_disable_pin_sync[0], link.global_disable_pin_n};
    end
  end
  wire en_pin = en_sync[1];
  wire global_disable_pin_active = ~global_disable_pin_sync[1];

  // Fault flags, sticky; set wins over a read clear
  logic std_flag, warn_flag;
  logic [2:0] ar_flag, ro_flag;
  logic [2:0] ack_q;
  wire [2:0] ar_block, ro_block;
  logic st_lock;
  logic [CNT_W-1:0] low_cnt;
  logic low_long;
  mode_e mode, next_mode;
  wire selftest_bad = (selftest_result_i == SELFTEST_FAIL);
  wire wdt_bad = watchdog_timeout_failure_i | watchdog_reply_failure_i;
  wire [2:0] ack = link.half_bridge_recovery_ack;
  wire [2:0] ack_fell = ack_q & ~ack;
  wire [2:0] ack_rose = ~ack_q & ack;
  wire ack_ok = link.config_mode;
  // Bridge enable low pulse timing
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_cnt <= '0;
      low_long <= 1'b0;
    end else if (en_pin) begin
      low_cnt <= '0;
      low_long <= 1'b0;
    end else if (low_cnt != CNT_W'(CLEAR_CYCLES)) begin
      low_cnt <= low_cnt + 1'b1;
    end else begin
      low_long <= 1'b1;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      std_flag <= 1'b0;
      warn_flag <= 1'b0;
      ar_flag <= 3'h0;
      ro_flag <= 3'h0;
    end else begin
      std_flag <= shutdown_fault_i | (std_flag & ~link.flag_read);
      warn_flag <= warning_fault_i | (warn_flag & ~link.flag_read);
      ar_flag <= autoretry_fault_i | (ar_flag & {3{~link.flag_read}});
      ro_flag <= reduced_fault_i | (ro_flag & {3{~link.flag_read}});
    end
  end
  // Acknowledge history for edge detection
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q <= ACK_RESET;
    end else begin
      ack_q <= ack;
    end
  end

  // per bridge recovery, ack 0 then 1 after clear
  for (genvar g = 0; g < NUM_HB; g++) begin : g_recover
    logic armed_ar, armed_ro, blk_ar, blk_ro;
    // auto-retry arm once fault gone and flag cleared
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        armed_ar <= 1'b0;
      end else if (ar_flag[g] | autoretry_fault_i[g]) begin
        armed_ar <= 1'b0;
      end else if (ack_fell[g] & ack_ok) begin
        armed_ar <= 1'b1;
      end
    end

    // reduced arm once fault gone and flag cleared
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        armed_ro <= 1'b0;
      end else if (ro_flag[g] | reduced_fault_i[g]) begin
        armed_ro <= 1'b0;
      end else if (ack_fell[g] & ack_ok) begin
        armed_ro <= 1'b1;
      end
    end

    // auto-retry block, set by fault, freed by ack 1
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        blk_ar <= 1'b0;
      end else if (autoretry_fault_i[g]) begin
        blk_ar <= 1'b1;
      end else if (armed_ar & ack_rose[g] & ack_ok) begin
        blk_ar <= 1'b0;
      end
    end

    // reduced block, set by fault, freed by ack 1
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        blk_ro <= 1'b0;
      end else if (reduced_fault_i[g]) begin
        blk_ro <= 1'b1;
      end else if (armed_ro & ack_rose[g] & ack_ok) begin
        blk_ro <= 1'b0;
      end
    end
    assign ar_block[g] = blk_ar;
    assign ro_block[g] = blk_ro;
  end : g_recover

  // self-test cause held until software reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_lock <= 1'b0;
    end else if (selftest_bad) begin
      st_lock <= 1'b1;
    end else if (link.software_reset_command) begin
      st_lock <= 1'b0;
    end
  end

  always_comb begin
    next_mode = mode;
    case (mode)
      MODE_NORMAL: begin
        if (selftest_bad | wdt_bad) next_mode = MODE_LOCKED;
        else if (shutdown_fault_i) next_mode = MODE_SAFE_OFF;
      end
      MODE_SAFE_OFF: begin
        // leave after clear and long low pulse
        if (selftest_bad | wdt_bad) next_mode = MODE_LOCKED;
        else if (!shutdown_fault_i && !std_flag && low_long && en_pin) next_mode = MODE_NORMAL;
      end
      MODE_LOCKED: begin
        if (link.software_reset_command) next_mode = MODE_NORMAL;
        // watchdog failure also released by watchdog reset
        else if (!st_lock && !selftest_bad && link.watchdog_reset_command) next_mode = MODE_NORMAL;
      end
      default: next_mode = MODE_NORMAL;
    endcase
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) mode <= MODE_NORMAL;
    else mode <= next_mode;
  end
  // shutdown dominates, then auto-retry, then reduced
  wire safe_off = (mode != MODE_NORMAL) | shutdown_fault_i;
  wire ar_any = |(ar_block | autoretry_fault_i);
  // combinational half bridge disable; reduced fault only failing bridge, auto-retry all; warning absent
  wire [2:0] hb_dis = link.half_bridge_disable_bit | {3{~en_pin | safe_off | predriver_supply_uv_i |
                      global_disable_pin_active | ar_any}} | ro_block | reduced_fault_i;
  wire pump_off = safe_off | global_disable_pin_active;
  wire [1:0] pump_dis = {link.pump_two_disable_bit, link.pump_one_disable_bit} | {2{pump_off}};
  assign hb_enable_o = ~hb_dis;
  assign pump_enable_o = ~pump_dis;
  assign mode_o = mode;
  // error bits and pin; warning leaves them
  wire err_any = safe_off | std_flag | (|ar_flag) | (|ro_flag) | ar_any | (|ro_block);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      link.frame_error_status_bits <= ERR_NONE;
      link.fault_signal_pin <= 1'b1;
    end else begin
      link.frame_error_status_bits <= err_any ? ERR_STD : ERR_NONE;
      link.fault_signal_pin <= ~err_any;
    end
  end

  // echo actual enable states, flags for readback
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      link.half_bridge_enable_echo <= 3'h0;
      link.pump_enable_echo <= 2'h0;
      link.fault_flags <= 8'h0;
    end else begin
      link.half_bridge_enable_echo <= ~hb_dis;
      link.pump_enable_echo <= ~pump_dis;
      link.fault_flags <= {std_flag, warn_flag, ro_flag, ar_flag};
    end
  end
endmodule : fault_device

// File: fault_host.sv
// Host controller end: APB registers drive the gate driver control pins
module fault_host import fault_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  fault_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  logic [31:0] ctrl;
  logic [2:0] hb_dis, ack;
  logic [2:0] cmd;
  logic rd_pulse;
  logic [CNT_W-1:0] low_cnt;
  logic [1:0] fs_sync;
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire mapped = (paddr == OFS_CTRL) | (paddr == OFS_HB_DIS) | (paddr == OFS_ACK) |
                (paddr == OFS_CMD) | (paddr == OFS_STATUS) | (paddr == OFS_FLAGS);
  // hold enable low at least the clear time
  wire en_req = ctrl[CTRL_BRIDGE_EN_BIT];
  wire low_done = (low_cnt >= CNT_W'(CLEAR_CYCLES));
  assign pready = ~(wr & (paddr == OFS_CTRL) & pwdata[CTRL_BRIDGE_EN_BIT] & ~link.bridge_enable_pin & ~low_done);
  assign pslverr = acc & ~mapped;
  // Register writes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RESET;
      hb_dis <= 3'h0;
      ack <= ACK_RESET;
      cmd <= 3'h0;
      rd_pulse <= 1'b0;
    end else begin
      cmd[1:0] <= 2'h0;
      rd_pulse <= rd & pready & (paddr == OFS_FLAGS);
      if (wr & pready) begin
        if (paddr == OFS_CTRL) ctrl <= pwdata;
        if (paddr == OFS_HB_DIS) hb_dis <= pwdata[2:0];
        // ack writes only take effect in configuration mode
        if (paddr == OFS_ACK && cmd[CMD_CFG_MODE_BIT]) ack <= pwdata[2:0];
        if (paddr == OFS_CMD) cmd <= pwdata[2:0];
      end
    end
  end
  // Enable pin low time counter
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) low_cnt <= '0;
    else if (link.bridge_enable_pin) low_cnt <= '0;
    else if (!low_done) low_cnt <= low_cnt + 1'b1;
  end
  // Fault pin synchroniser
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) fs_sync <= 2'h3;
    else fs_sync <= {fs_sync[0], link.fault_signal_pin};
  end
  // Read data
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) prdata <= 32'h0;
    else if (psel & ~penable & ~pwrite) begin
      case (paddr)
        OFS_CTRL: prdata <= ctrl;
        OFS_HB_DIS: prdata <= {29'h0, hb_dis};
        OFS_ACK: prdata <= {29'h0, ack};
        OFS_CMD: prdata <= {29'h0, cmd};
        OFS_STATUS: prdata <= {22'h0, fs_sync[1], link.frame_error_status_bits,
                               link.pump_enable_echo, link.half_bridge_enable_echo, 2'h0};
        OFS_FLAGS: prdata <= {24'h0, link.fault_flags};
        default: prdata <= 32'h0;
      endcase
    end
  end
  // Pin drive
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) link.bridge_enable_pin <= 1'b0;
    else link.bridge_enable_pin <= en_req;
  end
  assign link.global_disable_pin_n = ~ctrl[CTRL_GLOBAL_DIS_BIT];
  assign link.half_bridge_disable_bit = hb_dis;
  assign link.pump_one_disable_bit = ctrl[CTRL_PUMP1_DIS_BIT];
  assign link.pump_two_disable_bit = ctrl[CTRL_PUMP2_DIS_BIT];
  assign link.half_bridge_recovery_ack = ack;
  assign link.config_mode = cmd[CMD_CFG_MODE_BIT];
  assign link.software_reset_command = cmd[CMD_SW_RESET_BIT];
  assign link.watchdog_reset_command = cmd[CMD_WDT_RESET_BIT];
  assign link.flag_read = rd_pulse;
endmodule : fault_host

// File: fault_link_chk.sv
// Checker of the fault link between the host end and the gate driver end
module fault_link_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bridge_enable_pin,
  input wire logic global_disable_pin_n,
  input wire logic fault_signal_pin,
  input wire logic [2:0] half_bridge_disable_bit,
  input wire logic [1:0] frame_error_status_bits,
  input wire logic [2:0] half_bridge_enable_echo,
  input wire logic [1:0] pump_enable_echo,
  input wire logic [7:0] fault_flags
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Pin and error bits tell the same story
  a_pin_err_agree: assert property ((fault_signal_pin == (frame_error_status_bits == 2'h0))
    && (frame_error_status_bits inside {2'h0, 2'h3})) else $error("fault pin and error bits disagree");
  // Any uncleared non-warning flag shows as error
  a_flag_err_set: assert property ((fault_flags & 8'hBF) != 8'h0 [*2] |->
    frame_error_status_bits == 2'h3) else $error("error bits not set by fault flag");
  // Warning alone keeps the pin high
  a_warn_quiet: assert property (fault_flags == 8'h40 [*3] |-> fault_signal_pin)
    else $error("warning pulled the fault pin");
  // Disable bit held forces the echo off
  a_hb_dis_off: assert property ((half_bridge_disable_bit & $past(half_bridge_disable_bit)
    & $past(half_bridge_disable_bit, 2) & half_bridge_enable_echo) == 3'h0) else $error("disabled bridge echoed on");
  // Bridge enable pin low turns all bridges off
  a_en_low_off: assert property (!bridge_enable_pin [*5] |-> half_bridge_enable_echo == 3'h0)
    else $error("bridge on with enable pin low");
  // Global disable turns bridges and pumps off
  a_gdis_off: assert property (!global_disable_pin_n [*5] |-> (half_bridge_enable_echo == 3'h0)
    && (pump_enable_echo == 2'h0)) else $error("output on during global disable");
  // Shutdown flag keeps everything off
  a_std_safe: assert property (fault_flags[7] [*3] |-> (half_bridge_enable_echo == 3'h0)
    && (pump_enable_echo == 2'h0)) else $error("output on during shutdown");
  // Auto-retry flag keeps all bridges off
  a_ar_all_off: assert property ((fault_flags[2:0] != 3'h0) [*3] |-> half_bridge_enable_echo == 3'h0)
    else $error("bridge on during auto-retry fault");
endmodule : fault_link_chk

// File: tb_fault_reaction_disable_logic.sv
// Testbench of the host and gate driver fault ends joined back to back
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; $display("Error %s exp %h got %h", nm, e, g); end end
module tb_fault_reaction_disable_logic;
  timeunit 1ns;
  timeprecision 1ns;
  import fault_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic sd = 1'b0, warn = 1'b0, uv = 1'b0, wto = 1'b0, wre = 1'b0;
  logic [2:0] ar = 3'h0, ro = 3'h0, hb_en, z;
  logic [1:0] st = 2'h0, pump_en, mode;
  int checks = 0, n_fail = 0;
  fault_if bus ();
  fault_host u_fault_host (.clk_i(clk_i), .rst_i(rst_i), .link(bus.host), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  fault_device u_fault_device (.clk_i(clk_i), .rst_i(rst_i), .link(bus.device), .shutdown_fault_i(sd),
    .autoretry_fault_i(ar), .reduced_fault_i(ro), .warning_fault_i(warn), .predriver_supply_uv_i(uv),
    .selftest_result_i(st), .watchdog_timeout_failure_i(wto), .watchdog_reply_failure_i(wre),
    .hb_enable_o(hb_en), .pump_enable_o(pump_en), .mode_o(mode));
  fault_link_chk u_fault_link_chk (.clk_i(clk_i), .rst_i(rst_i), .bridge_enable_pin(bus.bridge_enable_pin),
    .global_disable_pin_n(bus.global_disable_pin_n), .fault_signal_pin(bus.fault_signal_pin),
    .half_bridge_disable_bit(bus.half_bridge_disable_bit), .frame_error_status_bits(bus.frame_error_status_bits),
    .half_bridge_enable_echo(bus.half_bridge_enable_echo), .pump_enable_echo(bus.pump_enable_echo),
    .fault_flags(bus.fault_flags));
  // Clock of 50 ns period
  always #25 clk_i = ~clk_i;
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    // Sample pready at the rising edge that takes the transfer
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Let outputs and echoes settle
  task automatic idle;
    repeat (8) @(posedge clk_i);
  endtask : idle
  // Compare enables, echoes, mode, pin and error bits
  task automatic look(input logic [2:0] h, input logic [1:0] p, input logic [1:0] m, input logic f,
    input logic [1:0] e);
    `CHK("hb", h, hb_en)
    `CHK("hb_echo", h, bus.half_bridge_enable_echo)
    `CHK("pump", p, pump_en)
    `CHK("pump_echo", p, bus.pump_enable_echo)
    `CHK("mode", m, mode)
    `CHK("pin", f, bus.fault_signal_pin)
    `CHK("err", e, bus.frame_error_status_bits)
  endtask : look
  // Acknowledge write pair, inside or outside config mode
  task automatic ack(input logic [2:0] a0, input logic cfg);
    apb(1'b1, OFS_CMD, {29'h0, cfg, 2'h0});
    apb(1'b1, OFS_ACK, {29'h0, a0});
    apb(1'b1, OFS_ACK, 32'h7);
    apb(1'b1, OFS_CMD, 32'h0);
    idle();
  endtask : ack
  // Verdict and end of run
  task automatic end_sim;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge clk_i);
    n_fail++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h1);
    idle();
    look(3'h7, 2'h3, MODE_NORMAL, 1'b1, ERR_NONE);
    apb(1'b1, OFS_HB_DIS, 32'h4);
    idle();
    look(3'h3, 2'h3, MODE_NORMAL, 1'b1, ERR_NONE);
    apb(1'b1, OFS_HB_DIS, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h3);
    idle();
    look(3'h7, 2'h2, MODE_NORMAL, 1'b1, ERR_NONE);
    apb(1'b1, OFS_CTRL, 32'h9);
    idle();
    look(3'h0, 2'h0, MODE_NORMAL, 1'b1, ERR_NONE);
    apb(1'b1, OFS_CTRL, 32'h1);
    uv <= 1'b1;
    idle();
    `CHK("hb_uv", 3'h0, hb_en)
    uv <= 1'b0;
    apb(1'b0, 8'h20, 32'h0);
    `CHK("pslverr", 1'b1, err)
    warn <= 1'b1;
    idle();
    look(3'h7, 2'h3, MODE_NORMAL, 1'b1, ERR_NONE);
    `CHK("flags_warn", 8'h40, bus.fault_flags)
    warn <= 1'b0;
    apb(1'b0, OFS_FLAGS, 32'h0);
    idle();
    `CHK("flags_clr", 8'h00, bus.fault_flags)
    for (int k = 0; k < 6; k++) begin
      z = ~(3'h1 << (k % 3));
      if (k < 3) ro <= ~z; else ar <= ~z;
      idle();
      look((k < 3) ? z : 3'h0, 2'h3, MODE_NORMAL, 1'b0, ERR_STD);
      ro <= 3'h0;
      ar <= 3'h0;
      idle();
      look((k < 3) ? z : 3'h0, 2'h3, MODE_NORMAL, 1'b0, ERR_STD);
      apb(1'b0, OFS_FLAGS, 32'h0);
      `CHK("flags_rd", (k < 3) ? {26'h0, ~z, 3'h0} : {29'h0, ~z}, rd)
      ack(z, 1'b0);
      look((k < 3) ? z : 3'h0, 2'h3, MODE_NORMAL, 1'b0, ERR_STD);
      ack(z, 1'b1);
      look(3'h7, 2'h3, MODE_NORMAL, 1'b1, ERR_NONE);
    end
    sd <= 1'b1;
    ro <= 3'h4;
    idle();
    look(3'h0, 2'h0, MODE_SAFE_OFF, 1'b0, ERR_STD);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("status_sd", 32'h180, rd)
    sd <= 1'b0;
    ro <= 3'h0;
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h1);
    idle();
    `CHK("mode_early", MODE_SAFE_OFF, mode)
    apb(1'b0, OFS_FLAGS, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h1);
    idle();
    `CHK("mode_exit", MODE_NORMAL, mode)
    ack(3'h3, 1'b1);
    look(3'h7, 2'h3, MODE_NORMAL, 1'b1, ERR_NONE);
    for (int j = 0; j < 3; j++) begin
      if (j == 0) st <= SELFTEST_FAIL; else if (j == 1) wto <= 1'b1; else wre <= 1'b1;
      idle();
      `CHK("locked", MODE_LOCKED, mode)
      `CHK("hb_locked", 3'h0, hb_en)
      st <= 2'h0;
      wto <= 1'b0;
      wre <= 1'b0;
      idle();
      `CHK("still_locked", MODE_LOCKED, mode)
      if (j == 0) begin
        apb(1'b1, OFS_CMD, 32'h2);
        idle();
        `CHK("st_no_wdt_exit", MODE_LOCKED, mode)
      end
      apb(1'b1, OFS_CMD, (j == 0) ? 32'h1 : 32'h2);
      idle();
      `CHK("unlocked", MODE_NORMAL, mode)
    end
    end_sim();
  end
endmodule : tb_fault_reaction_disable_logic
